// ==== rtl/rff_pkg.sv ====
// constants and register map of the receive frame filter
package rff_pkg;
   localparam int RFF_AW = 8;
   localparam int RFF_WIN_BYTES = 64;
   // register indices on the register port
   localparam logic [7:0] RFF_REG_CTRL = 8'h00;
   localparam logic [7:0] RFF_REG_STA0 = 8'h01;
   localparam logic [7:0] RFF_REG_PCS_LO = 8'h07;
   localparam logic [7:0] RFF_REG_PCS_HI = 8'h08;
   localparam logic [7:0] RFF_REG_POFF_LO = 8'h09;
   localparam logic [7:0] RFF_REG_POFF_HI = 8'h0A;
   localparam logic [7:0] RFF_REG_MASK0 = 8'h10;
   // rx_filter_control fields
   localparam int RFF_B_STATION = 7;
   localparam int RFF_B_COMBINE = 6;
   localparam int RFF_B_CRC = 5;
   localparam int RFF_B_PATTERN = 4;
   localparam int RFF_B_WAKEUP = 3;
   localparam int RFF_B_HASH = 2;
   localparam int RFF_B_GROUP = 1;
   localparam int RFF_B_ALLONES = 0;
   localparam logic [7:0] RFF_CTRL_RST = 8'hA1;
   localparam logic [7:0] RFF_CTRL_TESTS = 8'h9F;
   localparam int RFF_ADDR_BYTES = 6;
endpackage

// ==== rtl/rff_filter.sv ====
// receive frame filter: six frame tests combined by and/or, promiscuous bypass
//
// Behaviour
// (RQ1) six tests: station, pattern checksum, wake-up, hash, group, all-ones address.
// (RQ2) one eight-bit control register holds test enables, combine select, crc check.
// (RQ3) any mix of tests may be enabled; only enabled ones vote.
// (RQ4) control bit six selects and-combine (1) or or-combine (0).
// (RQ5) and-mode keeps a frame only if every enabled test accepts.
// (RQ6) or-mode keeps a frame if at least one enabled test accepts; the code still drops it when the crc check is on and the crc is bad.
// (RQ7) control register all zero keeps every frame, no test applied.
// (RQ8) failing frames are rejected in hardware without host help.
// (RQ9) verdict given at frame end; rejected frames advance nothing downstream.
// (RQ10) station test needs destination equal to the six-byte station address.
// (RQ11) pattern test: ones-complement sum of masked window bytes equals expected; the code compares the inverted sum.
// (RQ12) pattern test fails if the 64-byte window passes the last crc byte.
// (RQ13) unmasked bytes are dropped from the sum, not added as zero.
`timescale 1ns/1ps
module rff_filter #(
   parameter int WIN_BYTES = rff_pkg::RFF_WIN_BYTES
) (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic reg_wr_in,
   input wire logic [rff_pkg::RFF_AW-1:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_data_in,
   input wire logic rx_sof_in,
   input wire logic rx_eof_in,
   input wire logic rx_crc_ok_in,
   input wire logic hash_hit_in,
   input wire logic wakeup_hit_in,
   output logic frame_keep_out,
   output logic frame_drop_out
);
   import rff_pkg::*;

   localparam int MASK_REGS = WIN_BYTES / 8;

   // elaboration-time refusal of window sizes the mask map cannot serve
   if (WIN_BYTES < 8 || WIN_BYTES % 8 != 0 || MASK_REGS > 32) begin
      $error("rff_filter: WIN_BYTES must be a multiple of 8 from 8 to 256");
   end

   typedef struct packed {
      logic [7:0] ctrl;
      logic [47:0] station_address;
      logic [15:0] pattern_checksum_expected;
      logic [15:0] pattern_window_offset;
      logic [WIN_BYTES-1:0] pattern_byte_mask;
      logic [15:0] cnt;
      logic in_frame;
      logic sta_ok;
      logic ones_ok;
      logic group_bit;
      logic hash_ok;
      logic wake_ok;
      logic crc_ok;
      logic [15:0] sum;
      logic [7:0] hi_byte;
      logic half;
      logic judge;
      logic keep;
      logic drop;
      logic [7:0] rdata;
   } rff_state_t;

   rff_state_t state_ff;
   rff_state_t nxt_state;

   // ones-complement 16-bit add with end-around carry
   function automatic logic [15:0] rff_oc_add(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] t;
      t = {1'b0, a} + {1'b0, b};
      return t[15:0] + {15'h0000, t[16]};
   endfunction

   // mask register number for an address, or MASK_REGS when none
   function automatic int rff_mask_idx(input logic [7:0] addr);
      int k;
      k = MASK_REGS;
      if (addr >= RFF_REG_MASK0 && int'(addr - RFF_REG_MASK0) < MASK_REGS) begin
         k = int'(addr - RFF_REG_MASK0);
      end
      return k;
   endfunction

   always_comb begin
      logic [16:0] pos;
      logic [16:0] win_end;
      logic [15:0] fin_sum;
      logic pat_ok;
      logic [7:0] votes;
      logic [7:0] en;
      logic verdict;
      int mi;
      int ri;
      nxt_state = state_ff;
      pos = 17'h00000;
      win_end = 17'h00000;
      fin_sum = 16'h0000;
      pat_ok = 1'b0;
      votes = 8'h00;
      en = 8'h00;
      verdict = 1'b0;
      mi = rff_mask_idx(reg_addr_in);
      ri = 0;
      nxt_state.keep = 1'b0;
      nxt_state.drop = 1'b0;
      nxt_state.judge = 1'b0;

      // register writes
      if (reg_wr_in) begin
         if (reg_addr_in == RFF_REG_CTRL) begin
            nxt_state.ctrl = reg_wdata_in; // [RQ2]
         end else if (reg_addr_in >= RFF_REG_STA0 &&
                      reg_addr_in < RFF_REG_STA0 + 8'(RFF_ADDR_BYTES)) begin
            ri = int'(reg_addr_in - RFF_REG_STA0);
            nxt_state.station_address[ri*8 +: 8] = reg_wdata_in;
         end else if (reg_addr_in == RFF_REG_PCS_LO) begin
            nxt_state.pattern_checksum_expected[7:0] = reg_wdata_in;
         end else if (reg_addr_in == RFF_REG_PCS_HI) begin
            nxt_state.pattern_checksum_expected[15:8] = reg_wdata_in;
         end else if (reg_addr_in == RFF_REG_POFF_LO) begin
            nxt_state.pattern_window_offset[7:0] = reg_wdata_in;
         end else if (reg_addr_in == RFF_REG_POFF_HI) begin
            nxt_state.pattern_window_offset[15:8] = reg_wdata_in;
         end else if (mi < MASK_REGS) begin
            nxt_state.pattern_byte_mask[mi*8 +: 8] = reg_wdata_in;
         end
      end

      // register readback, one cycle after the address; unmapped reads zero
      nxt_state.rdata = 8'h00;
      if (reg_addr_in == RFF_REG_CTRL) begin
         nxt_state.rdata = state_ff.ctrl;
      end else if (reg_addr_in >= RFF_REG_STA0 &&
                   reg_addr_in < RFF_REG_STA0 + 8'(RFF_ADDR_BYTES)) begin
         ri = int'(reg_addr_in - RFF_REG_STA0);
         nxt_state.rdata = state_ff.station_address[ri*8 +: 8];
      end else if (reg_addr_in == RFF_REG_PCS_LO) begin
         nxt_state.rdata = state_ff.pattern_checksum_expected[7:0];
      end else if (reg_addr_in == RFF_REG_PCS_HI) begin
         nxt_state.rdata = state_ff.pattern_checksum_expected[15:8];
      end else if (reg_addr_in == RFF_REG_POFF_LO) begin
         nxt_state.rdata = state_ff.pattern_window_offset[7:0];
      end else if (reg_addr_in == RFF_REG_POFF_HI) begin
         nxt_state.rdata = state_ff.pattern_window_offset[15:8];
      end else if (mi < MASK_REGS) begin
         nxt_state.rdata = state_ff.pattern_byte_mask[mi*8 +: 8];
      end

      // byte stream; a new start of frame restarts all accumulators
      if (rx_valid_in) begin
         if (rx_sof_in) begin
            nxt_state.in_frame = 1'b1;
            nxt_state.cnt = 16'h0000;
            nxt_state.sta_ok = 1'b1;
            nxt_state.ones_ok = 1'b1;
            nxt_state.group_bit = 1'b0;
            nxt_state.sum = 16'h0000;
            nxt_state.half = 1'b0;
         end
         if (rx_sof_in || state_ff.in_frame) begin
            if (rx_sof_in) begin
               pos = 17'h00000;
            end else begin
               pos = {1'b0, state_ff.cnt};
            end
            if (pos < 17'(RFF_ADDR_BYTES)) begin
               if (rx_data_in != state_ff.station_address[pos[2:0]*8 +: 8]) begin
                  nxt_state.sta_ok = 1'b0; // [RQ10]
               end
               if (rx_data_in != 8'hFF) begin
                  nxt_state.ones_ok = 1'b0;
               end
               if (pos == 17'h00000) begin
                  nxt_state.group_bit = rx_data_in[0];
               end
            end
            win_end = {1'b0, state_ff.pattern_window_offset} + 17'(WIN_BYTES);
            if (pos >= {1'b0, state_ff.pattern_window_offset} && pos < win_end) begin
               ri = int'(pos - {1'b0, state_ff.pattern_window_offset});
               // masked-off bytes do not advance the byte pairing
               if (state_ff.pattern_byte_mask[ri]) begin // [RQ13]
                  if (nxt_state.half) begin
                     nxt_state.sum = rff_oc_add(nxt_state.sum,
                                                {nxt_state.hi_byte, rx_data_in}); // [RQ11]
                     nxt_state.half = 1'b0;
                  end else begin
                     nxt_state.hi_byte = rx_data_in;
                     nxt_state.half = 1'b1;
                  end
               end
            end
            nxt_state.cnt = 16'(pos + 17'h00001);
            if (rx_eof_in) begin
               nxt_state.in_frame = 1'b0;
               nxt_state.judge = 1'b1; // [RQ9]
               nxt_state.hash_ok = hash_hit_in;
               nxt_state.wake_ok = wakeup_hit_in;
               nxt_state.crc_ok = rx_crc_ok_in;
            end
         end
      end

      // verdict, the cycle after the last byte
      if (state_ff.judge) begin
         fin_sum = state_ff.sum;
         if (state_ff.half) begin
            fin_sum = rff_oc_add(fin_sum, {state_ff.hi_byte, 8'h00});
         end
         win_end = {1'b0, state_ff.pattern_window_offset} + 17'(WIN_BYTES);
         // a window past the last crc byte fails whatever the mask
         pat_ok = (win_end <= {1'b0, state_ff.cnt}) &&
                  (~fin_sum == state_ff.pattern_checksum_expected); // [RQ11] [RQ12]
         votes[RFF_B_STATION] = state_ff.sta_ok && state_ff.cnt >= 16'(RFF_ADDR_BYTES);
         votes[RFF_B_PATTERN] = pat_ok;
         votes[RFF_B_WAKEUP] = state_ff.wake_ok;
         votes[RFF_B_HASH] = state_ff.hash_ok;
         votes[RFF_B_GROUP] = state_ff.group_bit;
         votes[RFF_B_ALLONES] = state_ff.ones_ok && state_ff.cnt >= 16'(RFF_ADDR_BYTES); // [RQ1]
         en = state_ff.ctrl & RFF_CTRL_TESTS; // [RQ3]
         if (state_ff.ctrl == 8'h00) begin
            verdict = 1'b1; // [RQ7]
         end else if (en == 8'h00) begin
            verdict = 1'b1;
         end else if (state_ff.ctrl[RFF_B_COMBINE]) begin // [RQ4]
            verdict = ((votes & en) == en); // [RQ5]
         end else begin
            verdict = ((votes & en) != 8'h00); // [RQ6]
         end
         if (state_ff.ctrl[RFF_B_CRC] && !state_ff.crc_ok) begin
            verdict = 1'b0;
         end
         nxt_state.keep = verdict;
         nxt_state.drop = !verdict; // [RQ8]
      end
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_ff <= '0;
         state_ff.ctrl <= RFF_CTRL_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign reg_rdata_out = state_ff.rdata;
   assign frame_keep_out = state_ff.keep;
   assign frame_drop_out = state_ff.drop;
endmodule

// ==== bench/rff_filter_sva.sv ====
// port assertions for the receive frame filter
`timescale 1ns/1ps
module rff_filter_sva (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic reg_wr_in,
   input wire logic [rff_pkg::RFF_AW-1:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic rx_valid_in,
   input wire logic rx_sof_in,
   input wire logic rx_eof_in,
   input wire logic rx_crc_ok_in,
   input wire logic hash_hit_in,
   input wire logic wakeup_hit_in,
   input wire logic frame_keep_out,
   input wire logic frame_drop_out
);
   import rff_pkg::*;
   logic [7:0] ctrl_ff;
   logic in_frame_ff;
   // control value the design judges with: a write on the eof edge already counts
   wire [7:0] ctrl_nx = (reg_wr_in && reg_addr_in == RFF_REG_CTRL) ? reg_wdata_in : ctrl_ff;
   wire eofb = rx_valid_in && rx_eof_in;
   wire fin = eofb && (rx_sof_in || in_frame_ff);
   wire verd = frame_keep_out || frame_drop_out;
   wire crc_fine = !ctrl_nx[RFF_B_CRC] || rx_crc_ok_in;
   wire or_m = fin && !ctrl_nx[RFF_B_COMBINE];
   wire and_m = fin && ctrl_nx[RFF_B_COMBINE];
   wire [7:0] tests = ctrl_nx & RFF_CTRL_TESTS;
   // shadow of the control register, so verdicts follow from port traffic
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ctrl_ff <= RFF_CTRL_RST;
         in_frame_ff <= 1'h0;
      end else begin
         if (reg_wr_in && reg_addr_in == RFF_REG_CTRL)
            ctrl_ff <= reg_wdata_in;
         if (rx_valid_in && (rx_sof_in || rx_eof_in))
            in_frame_ff <= !rx_eof_in;
      end
   end
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);
   one_verdict_a: assert property (!(frame_keep_out && frame_drop_out))
      else $error("keep and drop together");
   verdict_cause_a: assert property (verd |-> $past(eofb, 2))
      else $error("verdict without frame end");
   verdict_due_a: assert property (fin |-> ##2 verd)
      else $error("no verdict two cycles after frame end");
   prom_keep_a: assert property (fin && ctrl_nx == 8'h00 |-> ##2 frame_keep_out)
      else $error("promiscuous frame not kept");
   crc_drop_a: assert property (fin && !crc_fine |-> ##2 frame_drop_out)
      else $error("bad crc frame not dropped");
   or_hash_a: assert property (or_m && tests[RFF_B_HASH] && hash_hit_in && crc_fine
      |-> ##2 frame_keep_out) else $error("or mode hash hit not kept");
   and_hash_a: assert property (and_m && tests[RFF_B_HASH] && !hash_hit_in
      |-> ##2 frame_drop_out) else $error("and mode hash miss not dropped");
   or_wake_a: assert property (or_m && tests == 8'h08 && !wakeup_hit_in
      |-> ##2 frame_drop_out) else $error("wake-up miss not dropped");
   no_test_a: assert property (fin && ctrl_nx != 8'h00 && tests == 8'h00 && crc_fine
      |-> ##2 frame_keep_out) else $error("frame with no test enabled not kept");
   readback_a: assert property ($past(nrst_in) && $past(reg_addr_in) == RFF_REG_CTRL
      |-> reg_rdata_out == $past(ctrl_ff)) else $error("control readback wrong");
endmodule
bind rff_filter rff_filter_sva rff_filter_sva_i (.ref_clk_in, .nrst_in, .reg_wr_in,
   .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .rx_valid_in, .rx_sof_in, .rx_eof_in,
   .rx_crc_ok_in, .hash_hit_in, .wakeup_hit_in, .frame_keep_out, .frame_drop_out);

// ==== bench/rff_mac_model.sv ====
// mac receive path model: sends one twelve-byte frame per request
`timescale 1ns/1ps
module rff_mac_model (
   input wire logic ref_clk_in,
   input wire logic go_in,
   input wire logic [95:0] frame_in,
   output logic rx_valid_out,
   output logic [7:0] rx_data_out,
   output logic rx_sof_out,
   output logic rx_eof_out
);
   int idx = -1;
   // data line toggles between frames so stale bytes never look valid
   logic [7:0] junk = 8'h5A;
   always @(posedge ref_clk_in) begin
      junk <= ~junk;
      if (go_in && idx < 0)
         idx <= 0;
      else if (idx >= 0)
         idx <= (idx == 11) ? -1 : idx + 1;
   end
   assign rx_valid_out = idx >= 0;
   assign rx_sof_out = idx == 0;
   assign rx_eof_out = idx == 11;
   assign rx_data_out = (idx >= 0) ? frame_in[8*(11-idx) +: 8] : junk;
endmodule

// ==== bench/rff_filter_tb.sv ====
// self-checking bench for the receive frame filter
`timescale 1ns/1ps
module rff_filter_tb;
   import rff_pkg::*;
   localparam logic [95:0] FA = 96'h021122334455_66778899AABB;
   localparam logic [95:0] FB = {48'hFFFFFFFFFFFF, FA[47:0]};
   localparam logic [95:0] FX = FA ^ {8'h01, 88'h0};
   logic clk = 1'h0, nrst = 1'h0, wr = 1'h0, go = 1'h0;
   logic crc = 1'h1, hh = 1'h0, wk = 1'h0;
   logic [7:0] addr = 8'h00, wdata = 8'h00;
   logic [95:0] frm = FA;
   logic [7:0] rdata, data;
   logic vld, sof, eof, keep, drop;
   int errors = 0, n_tests = 0;
   always #2 clk = ~clk;
   rff_filter #(.WIN_BYTES(8)) rff_filter_i (.ref_clk_in(clk), .nrst_in(nrst),
      .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .rx_valid_in(vld), .rx_data_in(data), .rx_sof_in(sof), .rx_eof_in(eof),
      .rx_crc_ok_in(crc), .hash_hit_in(hh), .wakeup_hit_in(wk),
      .frame_keep_out(keep), .frame_drop_out(drop));
   rff_mac_model rff_mac_model_i (.ref_clk_in(clk), .go_in(go), .frame_in(frm),
      .rx_valid_out(vld), .rx_data_out(data), .rx_sof_out(sof), .rx_eof_out(eof));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'h1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      repeat (2) @(posedge clk);
      #1;
      chk("rdata", e, rdata);
   endtask
   // chw holds crc good, hash hit and wake-up hit, steady for the whole frame
   task automatic fr(input logic [7:0] c, input logic [95:0] f, input logic [2:0] chw,
                     input logic k);
      wreg(RFF_REG_CTRL, c);
      @(posedge clk);
      {crc, hh, wk} <= chw;
      frm <= f;
      go <= 1'h1;
      @(posedge clk);
      go <= 1'h0;
      repeat (30) begin
         @(posedge clk);
         #1;
         if (keep || drop)
            break;
      end
      chk("verdict", {k, !k}, {keep, drop});
   endtask
   task close_out;
      if (errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      close_out;
   end
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'h1;
      rreg(RFF_REG_CTRL, RFF_CTRL_RST);
      rreg(8'hFF, 8'h00);
      for (int k = 0; k < 6; k++)
         wreg(RFF_REG_STA0 + 8'(k), FA[95-8*k -: 8]);
      // window bytes 0 and 2 pair into one word, so the sum is 2244 inverted
      wreg(RFF_REG_PCS_LO, 8'hBB);
      wreg(RFF_REG_PCS_HI, 8'hDD);
      wreg(RFF_REG_POFF_LO, 8'h02);
      wreg(RFF_REG_MASK0, 8'h05);
      rreg(RFF_REG_PCS_HI, 8'hDD);
      fr(8'h80, FA, 3'h4, 1'h1);
      fr(8'h80, FX, 3'h4, 1'h0);
      fr(8'h02, FX, 3'h4, 1'h1);
      fr(8'h02, FA, 3'h4, 1'h0);
      fr(8'h01, FB, 3'h4, 1'h1);
      fr(8'h01, FA, 3'h4, 1'h0);
      fr(8'h00, FX, 3'h0, 1'h1);
      fr(8'hA0, FA, 3'h0, 1'h0);
      fr(8'h81, FA, 3'h4, 1'h1);
      fr(8'hC1, FA, 3'h4, 1'h0);
      fr(8'h04, FA, 3'h6, 1'h1);
      fr(8'h08, FA, 3'h4, 1'h0);
      fr(8'h4C, FA, 3'h5, 1'h0);
      fr(8'h0C, FA, 3'h5, 1'h1);
      fr(8'h20, FA, 3'h4, 1'h1);
      fr(8'h10, FA, 3'h4, 1'h1);
      wreg(RFF_REG_POFF_LO, 8'h05);
      fr(8'h10, FA, 3'h4, 1'h0);
      close_out;
   end
endmodule
